// ==== rtl/csis_pkg.sv ====
// Purpose: Shared constants for the clock status interrupt and sync block
// Assumes: One core clock; device registers indexed by a 3-bit word address
// Notes:   Host registers sit on APB as aligned 32-bit words
package csis_pkg;

  // ----------------------------------------------------------------
  // Link register indexes
  // ----------------------------------------------------------------
  localparam logic [2:0] IRQ_ENCLR_IDX = 3'h0;
  localparam logic [2:0] IRQ_ENSET_IDX = 3'h1;
  localparam logic [2:0] IRQ_FLAG_IDX  = 3'h2;
  localparam logic [2:0] STATUS_IDX    = 3'h3;
  localparam logic [2:0] FLL_CTRL_IDX  = 3'h4;
  localparam logic [2:0] FLL_SYNC_IDX  = 3'h5;
  localparam logic [2:0] BOD_CTRL_IDX  = 3'h6;

  // ----------------------------------------------------------------
  // Source bit positions
  // ----------------------------------------------------------------
  localparam int NUM_SRC        = 12;
  localparam int NUM_PIN        = 11;
  localparam int EXT_XTAL_BIT   = 0;
  localparam int SLOW_XTAL_BIT  = 1;
  localparam int SLOW_OSC_BIT   = 2;
  localparam int MID_OSC_BIT    = 3;
  localparam int FLL_READY_BIT  = 4;
  localparam int FLL_OOB_BIT    = 5;
  localparam int FLL_FINE_BIT   = 6;
  localparam int FLL_COARSE_BIT = 7;
  localparam int FLL_REFSTP_BIT = 8;
  localparam int BOD_READY_BIT  = 9;
  localparam int BOD_DETECT_BIT = 10;
  localparam int BOD_SYNCRDY_BIT = 11;
  localparam int READ_REQ_BIT   = 0;

  // ----------------------------------------------------------------
  // Reset values and sync lengths
  // ----------------------------------------------------------------
  localparam logic [NUM_SRC-1:0] IRQ_RESET = 12'h000;
  localparam logic [31:0] FLL_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] BOD_CTRL_RESET = 32'h0000_0000;
  localparam int FLL_SYNC_CYC = 4;
  localparam int BOD_SYNC_CYC = 6;
  localparam int CNT_W        = 4;

  // ----------------------------------------------------------------
  // Host APB map
  // ----------------------------------------------------------------
  localparam logic [7:0] HOST_CMD_OFS    = 8'h00;
  localparam logic [7:0] HOST_WDATA_OFS  = 8'h04;
  localparam logic [7:0] HOST_RDATA_OFS  = 8'h08;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h0c;
  localparam int CMD_WRITE_BIT  = 8;
  localparam int CMD_START_BIT  = 16;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_IRQ_BIT   = 2;

endpackage

// ==== rtl/csis_if.sv ====
// Purpose: Link between the register master and the status unit
// Assumes: Both ends on core_clk
// Notes:   req holds with addr, wr and wdata until ack pulses
`timescale 1ns/1ps
interface csis_if;
  logic        req;
  logic        wr;
  logic [2:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  logic        irq;
  logic        wake;

  modport device (
    input  req,
    input  wr,
    input  addr,
    input  wdata,
    output rdata,
    output ack,
    output irq,
    output wake
  );

  modport host (
    output req,
    output wr,
    output addr,
    output wdata,
    input  rdata,
    input  ack,
    input  irq,
    input  wake
  );
endinterface

// ==== rtl/csis_edge_sync.sv ====
// Purpose: Two-flop synchroniser with rising-edge detect per bit
// Assumes: Inputs asynchronous to core_clk
// Notes:   rise is one cycle wide, one to two cycles after the pin
`timescale 1ns/1ps
module csis_edge_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic metaR;
    logic syncR;
    logic prevR;
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        metaR <= 1'b0;
        syncR <= 1'b0;
        prevR <= 1'b0;
      end else begin
        metaR <= din[i];
        syncR <= metaR;
        prevR <= syncR;
      end
    end
    assign level[i] = syncR;
    assign rise[i]  = syncR & ~prevR;
  end

endmodule

// ==== rtl/csis_device.sv ====
// Purpose: Status flags, interrupt enables and register sync of the unit
// Assumes: Status pins asynchronous; link master holds req until ack
// Notes:   Stalls are shown by a late ack on the link
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module csis_device (
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  csis_if.device                            link,
  input  wire logic [csis_pkg::NUM_PIN-1:0] statusPins,
  input  wire logic                         fllEnablePin,
  output logic      [31:0]                  fllCtrl,
  output logic      [31:0]                  bodCtrl,
  output logic                              bodSyncReady
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FLL_WAIT,
    ST_BOD_WAIT,
    ST_BOD_READ
  } csis_state_e;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int NS = csis_pkg::NUM_SRC;
  localparam logic [csis_pkg::CNT_W-1:0] FLL_LOAD =
    csis_pkg::CNT_W'(csis_pkg::FLL_SYNC_CYC - 1);
  localparam logic [csis_pkg::CNT_W-1:0] BOD_LOAD =
    csis_pkg::CNT_W'(csis_pkg::BOD_SYNC_CYC - 1);

  csis_state_e                  state_r;
  csis_state_e                  state_nxt;
  logic [csis_pkg::NUM_PIN-1:0] pinLevel;
  logic [csis_pkg::NUM_PIN-1:0] pinRise;
  logic                         fllOn;
  logic [NS-1:0]                srcRise;
  logic [NS-1:0]                flag_r;
  logic [NS-1:0]                enable_r;
  logic                         irq_r;
  logic                         wake_r;
  logic                         wakeSet;
  logic                         wakeClr;
  logic                         ack_r;
  logic                         ack_nxt;
  logic [31:0]                  rdata_r;
  logic [31:0]                  rdata_nxt;
  logic [31:0]                  readMux;
  logic                         doWrite;
  logic                         autoSync;
  logic                         bodRdGo;
  logic [csis_pkg::CNT_W-1:0]   waitCnt_r;
  logic [31:0]                  fllCtrl_r;
  logic [31:0]                  fllView_r;
  logic                         fllReadValid_r;
  logic                         fllBusy_r;
  logic [csis_pkg::CNT_W-1:0]   fllCnt_r;
  logic                         fllSyncGo;
  logic                         fllWrOk;
  logic [31:0]                  bodCtrl_r;
  logic [31:0]                  bodPend_r;
  logic                         bodRdy_r;
  logic                         bodRdyPrev_r;
  logic [csis_pkg::CNT_W-1:0]   bodCnt_r;
  logic                         bodWrGo;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  csis_edge_sync #(
    .W (csis_pkg::NUM_PIN)
  ) u_status_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (statusPins),
    .level    (pinLevel),
    .rise     (pinRise)
  );

  csis_edge_sync #(
    .W (1)
  ) u_enable_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (fllEnablePin),
    .level    (fllOn),
    .rise     ()
  );

  assign srcRise = {bodRdy_r & ~bodRdyPrev_r, pinRise};

  // ----------------------------------------------------------------
  // Flags, enables and request line
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_r <= csis_pkg::IRQ_RESET;
    end else if (doWrite && link.addr == csis_pkg::IRQ_FLAG_IDX) begin
      // Set beats clear so an edge in the clearing cycle survives
      flag_r <= (flag_r & ~link.wdata[NS-1:0]) | srcRise;
    end else begin
      flag_r <= flag_r | srcRise;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable_r <= csis_pkg::IRQ_RESET;
    end else if (doWrite && link.addr == csis_pkg::IRQ_ENSET_IDX) begin
      enable_r <= enable_r | link.wdata[NS-1:0];
    end else if (doWrite && link.addr == csis_pkg::IRQ_ENCLR_IDX) begin
      enable_r <= enable_r & ~link.wdata[NS-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(flag_r & enable_r);
    end
  end

  // Wake path needs no clock edge, so the pin sets it directly
  assign wakeSet = statusPins[csis_pkg::BOD_DETECT_BIT]
                 & enable_r[csis_pkg::BOD_DETECT_BIT];
  assign wakeClr = doWrite && link.wdata[csis_pkg::BOD_DETECT_BIT]
                 && (link.addr == csis_pkg::IRQ_FLAG_IDX
                  || link.addr == csis_pkg::IRQ_ENCLR_IDX);

  always_ff @(posedge core_clk or posedge rst or posedge wakeSet) begin
    if (rst) begin
      wake_r <= 1'b0;
    end else if (wakeSet) begin
      wake_r <= 1'b1;
    end else if (wakeClr) begin
      wake_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    unique case (link.addr)
      csis_pkg::IRQ_ENCLR_IDX,
      csis_pkg::IRQ_ENSET_IDX: readMux = {20'h00000, enable_r};
      csis_pkg::IRQ_FLAG_IDX:  readMux = {20'h00000, flag_r};
      csis_pkg::STATUS_IDX:    readMux = {20'h00000, bodRdy_r, pinLevel};
      default:                 readMux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    ack_nxt   = 1'b0;
    rdata_nxt = rdata_r;
    doWrite   = 1'b0;
    autoSync  = 1'b0;
    bodRdGo   = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (link.req && !ack_r) begin
          if (link.wr) begin
            if (link.addr == csis_pkg::BOD_CTRL_IDX && !bodRdy_r) begin
              state_nxt = ST_BOD_WAIT;
            end else begin
              doWrite = 1'b1;
              ack_nxt = 1'b1;
            end
          end else if (link.addr == csis_pkg::FLL_CTRL_IDX) begin
            if (!fllOn) begin
              ack_nxt   = 1'b1;
              rdata_nxt = fllCtrl_r;
            end else if (fllReadValid_r) begin
              ack_nxt   = 1'b1;
              rdata_nxt = fllView_r;
            end else begin
              autoSync  = 1'b1;
              state_nxt = ST_FLL_WAIT;
            end
          end else if (link.addr == csis_pkg::BOD_CTRL_IDX) begin
            if (!bodRdy_r) begin
              state_nxt = ST_BOD_WAIT;
            end else begin
              bodRdGo   = 1'b1;
              state_nxt = ST_BOD_READ;
            end
          end else begin
            ack_nxt   = 1'b1;
            rdata_nxt = readMux;
          end
        end
      end
      ST_FLL_WAIT: begin
        if (fllReadValid_r || !fllOn) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_BOD_WAIT: begin
        if (bodRdy_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_BOD_READ: begin
        if (waitCnt_r == '0) begin
          ack_nxt   = 1'b1;
          rdata_nxt = bodCtrl_r;
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      waitCnt_r <= '0;
    end else if (bodRdGo) begin
      waitCnt_r <= BOD_LOAD;
    end else if (waitCnt_r != '0) begin
      waitCnt_r <= waitCnt_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Locked-loop register and read sync
  // ----------------------------------------------------------------
  assign fllWrOk = doWrite && link.addr == csis_pkg::FLL_CTRL_IDX
                && pinLevel[csis_pkg::FLL_READY_BIT];
  assign fllSyncGo = autoSync || (doWrite
                  && link.addr == csis_pkg::FLL_SYNC_IDX
                  && link.wdata[csis_pkg::READ_REQ_BIT]);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fllCtrl_r <= csis_pkg::FLL_CTRL_RESET;
    end else if (fllWrOk) begin
      fllCtrl_r <= link.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fllBusy_r      <= 1'b0;
      fllCnt_r       <= '0;
      fllView_r      <= csis_pkg::FLL_CTRL_RESET;
      fllReadValid_r <= 1'b0;
    end else if (fllBusy_r) begin
      if (fllCnt_r == '0) begin
        fllBusy_r      <= 1'b0;
        fllView_r      <= fllCtrl_r;
        fllReadValid_r <= 1'b1;
      end else begin
        fllCnt_r <= fllCnt_r - 1'b1;
      end
    end else if (fllSyncGo) begin
      fllBusy_r      <= 1'b1;
      fllCnt_r       <= FLL_LOAD;
      fllReadValid_r <= 1'b0;
    end else if (fllWrOk) begin
      // Fresh write makes the old snapshot stale
      fllReadValid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Brown-out control write sync
  // ----------------------------------------------------------------
  assign bodWrGo = doWrite && link.addr == csis_pkg::BOD_CTRL_IDX;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bodRdy_r  <= 1'b1;
      bodCnt_r  <= '0;
      bodPend_r <= csis_pkg::BOD_CTRL_RESET;
      bodCtrl_r <= csis_pkg::BOD_CTRL_RESET;
    end else if (bodWrGo) begin
      bodRdy_r  <= 1'b0;
      bodCnt_r  <= BOD_LOAD;
      bodPend_r <= link.wdata;
    end else if (!bodRdy_r) begin
      if (bodCnt_r == '0) begin
        bodRdy_r  <= 1'b1;
        bodCtrl_r <= bodPend_r;
      end else begin
        bodCnt_r <= bodCnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bodRdyPrev_r <= 1'b1;
    end else begin
      bodRdyPrev_r <= bodRdy_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.ack     = ack_r;
  assign link.rdata   = rdata_r;
  assign link.irq     = irq_r;
  assign link.wake    = wake_r;
  assign fllCtrl      = fllCtrl_r;
  assign bodCtrl      = bodCtrl_r;
  assign bodSyncReady = bodRdy_r;

endmodule

// ==== rtl/csis_host.sv ====
// Purpose: APB-driven master that issues link accesses to the unit
// Assumes: Software polls busy before a new command
// Notes:   One outstanding access; a start while busy is dropped
`timescale 1ns/1ps
module csis_host (
  input  wire logic        core_clk,
  input  wire logic        rst,
  csis_if.host             link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             hostIrq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        req_r;
  logic        wr_r;
  logic [2:0]  addr_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic        done_r;
  logic        irq_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        setup;
  logic        wrAcc;
  logic        mapped;
  logic        start;
  logic [31:0] readMux;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setup  = psel && !penable;
  assign wrAcc  = psel && penable && pready_r && pwrite && !pslverr_r;
  assign mapped = paddr == csis_pkg::HOST_CMD_OFS
               || paddr == csis_pkg::HOST_WDATA_OFS
               || paddr == csis_pkg::HOST_RDATA_OFS
               || paddr == csis_pkg::HOST_STATUS_OFS;

  always_comb begin
    readMux = 32'h0000_0000;
    if (paddr == csis_pkg::HOST_CMD_OFS) begin
      readMux = {23'h000000, wr_r, 5'h00, addr_r};
    end else if (paddr == csis_pkg::HOST_WDATA_OFS) begin
      readMux = wdata_r;
    end else if (paddr == csis_pkg::HOST_RDATA_OFS) begin
      readMux = rdata_r;
    end else if (paddr == csis_pkg::HOST_STATUS_OFS) begin
      readMux = {29'h00000000, irq_r, done_r, req_r};
    end
  end

  // Answer fixed one cycle after setup
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r  <= (setup && !pwrite) ? readMux : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdata_r <= 32'h0000_0000;
    end else if (wrAcc && paddr == csis_pkg::HOST_WDATA_OFS && !req_r) begin
      wdata_r <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Link master
  // ----------------------------------------------------------------
  assign start = wrAcc && paddr == csis_pkg::HOST_CMD_OFS
              && pwdata[csis_pkg::CMD_START_BIT] && !req_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_r   <= 1'b0;
      wr_r    <= 1'b0;
      addr_r  <= 3'h0;
      rdata_r <= 32'h0000_0000;
      done_r  <= 1'b0;
    end else if (start) begin
      req_r  <= 1'b1;
      wr_r   <= pwdata[csis_pkg::CMD_WRITE_BIT];
      addr_r <= pwdata[2:0];
      done_r <= 1'b0;
    end else if (req_r && link.ack) begin
      // Unit stalls by withholding ack; hold everything until then
      req_r   <= 1'b0;
      rdata_r <= link.rdata;
      done_r  <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= link.irq;
    end
  end

  assign link.req   = req_r;
  assign link.wr    = wr_r;
  assign link.addr  = addr_r;
  assign link.wdata = wdata_r;
  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign hostIrq    = irq_r;

endmodule

// ==== test/csis_properties.sv ====
// Purpose: Link-level checks between the register master and the unit
// Assumes: Single core_clk domain, async active-high rst
// Notes:   Indexes 0 enable-clear, 2 flag, 4 fll ctrl, 6 bod ctrl
`timescale 1ns/1ps
module csis_properties (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [2:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        irq,
  input wire logic        wake
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic clrHit;
  assign clrHit = ack && wr && (addr == 3'h0 || addr == 3'h2);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack wider than one cycle");
  a_req_held: assert property (req && !ack |=> req && $stable(addr))
    else $error("request dropped before answer");
  a_plain_ack: assert property ($rose(req) && addr <= 3'h3 |=> ack)
    else $error("irq register access not answered next cycle");
  a_enclr_irq: assert property (
    clrHit && addr == 3'h0 && wdata[11:0] == 12'hfff |=> ##[0:1] !irq)
    else $error("irq stays after all enables cleared");
  a_flagclr_irq: assert property (
    clrHit && addr == 3'h2 && wdata[11:0] == 12'hfff |=> ##[0:1] !irq)
    else $error("irq stays after all flags cleared");
  a_irq_fall: assert property (
    $fell(irq) |-> $past(clrHit) || $past(clrHit, 2))
    else $error("irq fell without a clear");
  a_wake_fall: assert property (
    $fell(wake) |-> clrHit)
    else $error("wake fell without a clear");
  a_bod_rd_delay: assert property (
    $rose(req) && !wr && addr == 3'h6 |=> !ack [*6])
    else $error("bod read answered without sync delay");
  a_bod_bound: assert property ($rose(req) && addr == 3'h6 |-> ##[1:20] ack)
    else $error("bod access stalled too long");
  a_fll_rd_bound: assert property (
    $rose(req) && !wr && addr == 3'h4 |-> ##[1:12] ack)
    else $error("fll read stalled too long");
  c_wake: cover property ($rose(wake));
  c_irq: cover property ($rose(irq));
  c_bod_rd: cover property ($rose(req) && !wr && addr == 3'h6);
endmodule

// ==== test/tb_csis.sv ====
// Purpose: Drives the unit through the APB master and its status pins
// Assumes: Both ends joined by one link; 50 MHz core_clk
// Notes:   Link traffic only through host commands, polled on busy
`timescale 1ns/1ps
module tb_csis;
  typedef struct {logic [10:0] pins; logic [11:0] flag; logic wake;} csis_row_s;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        hostIrq, fllEn, bodSyncReady;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, fllCtrl, bodCtrl, rd;
  logic [10:0] pins;
  int          nErrors, checked;
  csis_row_s   rows[11];
  csis_if      link();
  csis_host u_csis_host (.core_clk(core_clk), .rst(rst), .link(link.host),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hostIrq(hostIrq));
  csis_device u_csis_device (.core_clk(core_clk), .rst(rst),
    .link(link.device), .statusPins(pins), .fllEnablePin(fllEn),
    .fllCtrl(fllCtrl), .bodCtrl(bodCtrl), .bodSyncReady(bodSyncReady));
  csis_properties u_csis_properties (.core_clk(core_clk), .rst(rst),
    .req(link.req), .wr(link.wr), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .ack(link.ack), .irq(link.irq), .wake(link.wake));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      nErrors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    if (nErrors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Setup, then access held until pready seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task dev(input logic w, input logic [2:0] idx, input logic [31:0] d,
           output logic [31:0] r);
    logic e;
    apb(1'b1, csis_pkg::HOST_WDATA_OFS, d, r, e);
    apb(1'b1, csis_pkg::HOST_CMD_OFS, {15'h0, 1'b1, 7'h0, w, 5'h0, idx}, r, e);
    do apb(1'b0, csis_pkg::HOST_STATUS_OFS, 32'h0, r, e);
      while (r[csis_pkg::STAT_BUSY_BIT] !== 1'b0);
    apb(1'b0, csis_pkg::HOST_RDATA_OFS, 32'h0, r, e);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin core_clk = 1'b0; forever #10 core_clk = ~core_clk; end
  initial begin #400000; nErrors++; print_verdict; end
  initial begin : seq
    logic e;
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
    pwdata = 32'h0; pins = 11'h0; fllEn = 1'b0; nErrors = 0; checked = 0;
    for (int i = 0; i < 11; i++) rows[i] = '{11'(1 << i), 12'(1 << i), i == 10};
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk({link.irq, link.wake, bodSyncReady}, 32'h1);
    chk(fllCtrl, 32'h0);
    dev(1'b1, csis_pkg::IRQ_ENSET_IDX, 32'hfff, rd);
    foreach (rows[i]) begin
      pins <= rows[i].pins;
      repeat (6) @(posedge core_clk);
      dev(1'b0, csis_pkg::IRQ_FLAG_IDX, 32'h0, rd);
      chk(rd[11:0], rows[i].flag);
      chk(link.irq, 1'b1);
      chk(link.wake, rows[i].wake);
      pins <= 11'h0;
      dev(1'b1, csis_pkg::IRQ_FLAG_IDX, 32'hfff, rd);
      dev(1'b0, csis_pkg::IRQ_FLAG_IDX, 32'h0, rd);
      chk({rd[11:0], link.wake}, 32'h0);
    end
    dev(1'b1, csis_pkg::IRQ_ENCLR_IDX, 32'hfff, rd);
    pins <= 11'h001;
    repeat (6) @(posedge core_clk);
    chk({link.irq, hostIrq}, 32'h0);
    dev(1'b1, csis_pkg::IRQ_ENSET_IDX, 32'h001, rd);
    dev(1'b1, csis_pkg::IRQ_ENCLR_IDX, 32'h002, rd);
    chk({link.irq, hostIrq}, 32'h3);
    dev(1'b1, csis_pkg::IRQ_ENCLR_IDX, 32'hfff, rd);
    chk(link.irq, 1'b0);
    dev(1'b1, csis_pkg::FLL_CTRL_IDX, 32'ha5, rd);
    chk(fllCtrl, 32'h0);
    pins <= 11'h010;
    repeat (6) @(posedge core_clk);
    dev(1'b1, csis_pkg::FLL_CTRL_IDX, 32'h3c, rd);
    chk(fllCtrl, 32'h3c);
    fllEn <= 1'b1;
    repeat (4) @(posedge core_clk);
    dev(1'b0, csis_pkg::FLL_CTRL_IDX, 32'h0, rd);
    chk(rd, 32'h3c);
    dev(1'b1, csis_pkg::FLL_SYNC_IDX, 32'h1, rd);
    dev(1'b0, csis_pkg::FLL_CTRL_IDX, 32'h0, rd);
    chk(rd, 32'h3c);
    fllEn <= 1'b0;
    repeat (4) @(posedge core_clk);
    dev(1'b0, csis_pkg::FLL_CTRL_IDX, 32'h0, rd);
    chk(rd, 32'h3c);
    dev(1'b1, csis_pkg::BOD_CTRL_IDX, 32'h11, rd);
    dev(1'b1, csis_pkg::BOD_CTRL_IDX, 32'h22, rd);
    dev(1'b0, csis_pkg::BOD_CTRL_IDX, 32'h0, rd);
    chk(rd, 32'h22);
    chk({bodCtrl[7:0], bodSyncReady}, 32'h45);
    dev(1'b0, csis_pkg::IRQ_FLAG_IDX, 32'h0, rd);
    chk(rd[11], 1'b1);
    dev(1'b0, csis_pkg::STATUS_IDX, 32'h0, rd);
    chk(rd, 32'h810);
    apb(1'b0, 8'h40, 32'h0, rd, e);
    chk(e, 1'b1);
    print_verdict;
  end
endmodule
